/* hdl/otfr_consts.svh */
// constants for the over-temperature fault response block
`ifndef OTFR_CONSTS_SVH
`define OTFR_CONSTS_SVH

// ----------------------------------------------------------------------
// register map
// ----------------------------------------------------------------------
`define OTFR_REG_ACTION   8'h50 // fault action command code
`define OTFR_ACTION_RST   8'h00 // action value after reset
`define OTFR_RD_ZERO      8'h00 // answer for other command codes

// ----------------------------------------------------------------------
// retry field codes and counts
// ----------------------------------------------------------------------
`define OTFR_RETRY_NONE   3'h0 // no restart attempts
`define OTFR_RETRY_FOREVER 3'h7 // endless restart attempts
`define OTFR_TRIES_ZERO   3'h0 // attempt counter start
`define OTFR_TRIES_ONE    3'h1 // attempt counter step
`define OTFR_UNITS_ONE    8'h01 // one delay unit, base of 2**n
`define OTFR_PRESC_ZERO   24'h000000 // prescaler start

`endif

/* hdl/otfr_pkg.sv */
// types for the over-temperature fault response block
`default_nettype none
package otfr_pkg;

	// ------------------------------------------------------------------
	// response field encodings
	// ------------------------------------------------------------------
	typedef enum logic [1:0] {
		OTFR_RESP_IGNORE  = 2'b00, // keep running
		OTFR_RESP_DELAY   = 2'b01, // run for delay, then act
		OTFR_RESP_DISABLE = 2'b10, // shut down, then retry setting
		OTFR_RESP_HOLD    = 2'b11  // off while fault, resume after
	} otfr_resp_e;

	// ------------------------------------------------------------------
	// layout of the fault action byte
	// ------------------------------------------------------------------
	typedef struct packed {
		otfr_resp_e resp;    // bits 7:6
		logic [2:0] retries; // bits 5:3
		logic [2:0] delay;   // bits 2:0, 2**n units
	} otfr_action_s;

	// ------------------------------------------------------------------
	// fault response states
	// ------------------------------------------------------------------
	typedef enum logic [2:0] {
		OTFR_ST_NORMAL = 3'b000, // output follows command
		OTFR_ST_GRACE  = 3'b001, // running out the delay
		OTFR_ST_WAIT   = 3'b010, // off, waiting for next attempt
		OTFR_ST_HOLD   = 3'b011, // off until fault is gone
		OTFR_ST_LATCH  = 3'b100  // off until fault cleared
	} otfr_state_e;

endpackage
`default_nettype wire

/* hdl/otfr_delay_timer.sv */
// delay timer counting 2**n units of a programmable cycle length
`timescale 1ns/1ns
`default_nettype none
`include "otfr_consts.svh"

module otfr_delay_timer #(
	parameter int UNIT_W = 24 // width of the unit length in cycles
) (
	input  wire logic              i_mclk,        // system clock
	input  wire logic              i_rst,         // async reset, high
	input  wire logic              i_start,       // load and run
	input  wire logic              i_stop,        // abandon a run
	input  wire logic [2:0]        i_exp,         // count is 2**i_exp
	input  wire logic [UNIT_W-1:0] i_unit_cycles, // cycles per unit
	output logic                   o_done,        // one-cycle end pulse
	output logic                   o_busy         // a run is active
);

	// ------------------------------------------------------------------
	// elaboration check
	// ------------------------------------------------------------------
	if (UNIT_W < 1 || UNIT_W > 24)
		$error("otfr_delay_timer: UNIT_W must be 1 to 24");

	logic [UNIT_W-1:0] presc;      // cycles within the current unit
	logic [7:0]        left;       // units still to run
	logic [UNIT_W-1:0] next_presc; // next prescaler
	logic [7:0]        next_left;  // next unit count
	logic              next_busy;  // next busy
	logic              next_done;  // next end pulse
	logic              unit_end;   // last cycle of a unit

	// a zero unit length is served as one cycle per unit
	assign unit_end = (presc + 1'b1 >= i_unit_cycles);

	// next state of the timer
	always_comb
	begin
		next_presc = presc;
		next_left  = left;
		next_busy  = o_busy;
		next_done  = 1'b0;
		if (i_start)
		begin
			// start wins over a stop in the same cycle
			next_busy  = 1'b1;
			next_presc = UNIT_W'(`OTFR_PRESC_ZERO);
			next_left  = `OTFR_UNITS_ONE << i_exp;
		end
		else if (i_stop)
			next_busy = 1'b0;
		else if (o_busy)
		begin
			if (unit_end)
			begin
				// one unit elapsed
				next_presc = UNIT_W'(`OTFR_PRESC_ZERO);
				if (left == `OTFR_UNITS_ONE)
				begin
					next_busy = 1'b0;
					next_done = 1'b1;
				end
				else
					next_left = left - `OTFR_UNITS_ONE;
			end
			else
				next_presc = presc + 1'b1;
		end
	end

	// timer registers
	always_ff @(posedge i_mclk or posedge i_rst)
	begin
		if (i_rst)
		begin
			presc  <= UNIT_W'(`OTFR_PRESC_ZERO);
			left   <= `OTFR_UNITS_ONE;
			o_busy <= 1'b0;
			o_done <= 1'b0;
		end
		else
		begin
			presc  <= next_presc;
			left   <= next_left;
			o_busy <= next_busy;
			o_done <= next_done;
		end
	end

endmodule // otfr_delay_timer
`default_nettype wire

/* hdl/otfr_fault_response.sv */
// over-temperature fault response state machine with its command register
//
// How it works
// - response 00 keeps the output running
// - response 01 runs for delay, then retries
// - response 10 disables at once, then retries
// - response 11 off during fault, resumes after
// - retry 000 latches off until cleared
// - retry 1 to 6 gives that many attempts
// - all attempts failed latches output off
// - attempt spacing is delay count times unit
// - retry 111 retries until fault gone, commanded off or other fault
// - delay field selects two to the n units
// - unit length comes from separate configuration
// - fault pulls alert low and sets flag
`timescale 1ns/1ns
`default_nettype none
`include "otfr_consts.svh"

module otfr_fault_response #(
	parameter int UNIT_W = 24 // width of the unit length in cycles
) (
	input  wire logic              i_mclk,        // system clock
	input  wire logic              i_rst,         // async reset, high
	input  wire logic              i_wr_en,       // command write strobe
	input  wire logic [7:0]        i_wr_code,     // command code written
	input  wire logic [7:0]        i_wr_data,     // data byte written
	input  wire logic              i_rd_en,       // command read strobe
	input  wire logic [7:0]        i_rd_code,     // command code read
	input  wire logic [15:0]       i_temp,        // measured temperature
	input  wire logic [15:0]       i_limit,       // fault limit
	input  wire logic [UNIT_W-1:0] i_unit_cycles, // delay unit in cycles
	input  wire logic              i_cmd_on,      // output commanded on
	input  wire logic              i_other_fault, // other shutdown fault
	input  wire logic              i_clear_fault, // clear latched faults
	output logic [7:0]             o_rd_data,     // read answer byte
	output logic                   o_rd_valid,    // read answer strobe
	output logic                   o_output_en,   // power stage enable
	output logic                   o_ot_flag,     // sticky fault flag
	output logic                   o_alert_line_n // alert, low active
);

	// ------------------------------------------------------------------
	// elaboration check
	// ------------------------------------------------------------------
	if (UNIT_W < 1 || UNIT_W > 24)
		$error("otfr_fault_response: UNIT_W must be 1 to 24");

	// ------------------------------------------------------------------
	// command register
	// ------------------------------------------------------------------
	otfr_pkg::otfr_action_s action;      // fault action byte
	otfr_pkg::otfr_action_s next_action; // next action byte
	logic [7:0]             next_rd_data; // next read answer
	logic                   next_rd_valid; // next read strobe

	// decode writes and reads of the command codes
	always_comb
	begin
		next_action   = action;
		next_rd_data  = o_rd_data;
		next_rd_valid = i_rd_en;
		if (i_wr_en && i_wr_code == `OTFR_REG_ACTION)
			next_action = otfr_pkg::otfr_action_s'(i_wr_data);
		if (i_rd_en)
		begin
			// other command codes answer zero
			if (i_rd_code == `OTFR_REG_ACTION)
				next_rd_data = action;
			else
				next_rd_data = `OTFR_RD_ZERO;
		end
	end

	// register file flops
	always_ff @(posedge i_mclk or posedge i_rst)
	begin
		if (i_rst)
		begin
			action     <= otfr_pkg::otfr_action_s'(`OTFR_ACTION_RST);
			o_rd_data  <= `OTFR_RD_ZERO;
			o_rd_valid <= 1'b0;
		end
		else
		begin
			action     <= next_action;
			o_rd_data  <= next_rd_data;
			o_rd_valid <= next_rd_valid;
		end
	end

	// ------------------------------------------------------------------
	// fault detection with hysteresis at the limit
	// ------------------------------------------------------------------
	logic fault;      // fault condition present
	logic next_fault; // next fault condition

	// above sets, below clears, equal keeps
	always_comb
	begin
		next_fault = fault;
		if ($signed(i_temp) > $signed(i_limit))
			next_fault = 1'b1;
		else if ($signed(i_temp) < $signed(i_limit))
			next_fault = 1'b0;
	end

	// fault flop
	always_ff @(posedge i_mclk or posedge i_rst)
	begin
		if (i_rst)
			fault <= 1'b0;
		else
			fault <= next_fault;
	end

	// ------------------------------------------------------------------
	// delay timer
	// ------------------------------------------------------------------
	logic tmr_start; // load the timer
	logic tmr_stop;  // abandon the timer
	logic tmr_done;  // delay elapsed pulse

	// the unit length is held elsewhere and arrives as a count
	otfr_delay_timer #(
		.UNIT_W        (UNIT_W)
	) u_timer (
		.i_mclk        (i_mclk),
		.i_rst         (i_rst),
		.i_start       (tmr_start),
		.i_stop        (tmr_stop),
		.i_exp         (action.delay),
		.i_unit_cycles (i_unit_cycles),
		.o_done        (tmr_done),
		.o_busy        ()
	);

	// ------------------------------------------------------------------
	// response state machine
	// ------------------------------------------------------------------
	otfr_pkg::otfr_state_e state;      // current response state
	otfr_pkg::otfr_state_e next_state; // next response state
	logic [2:0]            tries;      // failed restart attempts
	logic [2:0]            next_tries; // next attempt count
	logic [3:0]            tries_inc;  // attempts after this one
	logic                  running;    // output commanded on and no other fault
	logic                  next_out_en; // next output enable

	assign running   = i_cmd_on & ~i_other_fault;
	assign tries_inc = {1'b0, tries} + {1'b0, `OTFR_TRIES_ONE};

	// next state, timer control and attempt count
	always_comb
	begin
		next_state = state;
		next_tries = tries;
		tmr_start  = 1'b0;
		tmr_stop   = 1'b0;
		if (!running)
		begin
			// commanded off or other fault ends any retrying
			next_state = otfr_pkg::OTFR_ST_NORMAL;
			tmr_stop   = 1'b1;
			next_tries = `OTFR_TRIES_ZERO;
		end
		else
		begin
			unique case (state)
			otfr_pkg::OTFR_ST_NORMAL:
			begin
				// react to a present fault per response field
				if (fault)
				begin
					unique case (action.resp)
					otfr_pkg::OTFR_RESP_IGNORE:
						next_state = otfr_pkg::OTFR_ST_NORMAL;
					otfr_pkg::OTFR_RESP_DELAY:
					begin
						next_state = otfr_pkg::OTFR_ST_GRACE;
						tmr_start  = 1'b1;
					end
					otfr_pkg::OTFR_RESP_DISABLE:
					begin
						// shut down now, then retry setting
						next_tries = `OTFR_TRIES_ZERO;
						if (action.retries == `OTFR_RETRY_NONE)
							next_state = otfr_pkg::OTFR_ST_LATCH;
						else
						begin
							next_state = otfr_pkg::OTFR_ST_WAIT;
							tmr_start  = 1'b1;
						end
					end
					otfr_pkg::OTFR_RESP_HOLD:
						next_state = otfr_pkg::OTFR_ST_HOLD;
					endcase
				end
			end
			otfr_pkg::OTFR_ST_GRACE:
			begin
				// still running; act only if fault outlasts delay
				if (!fault)
				begin
					next_state = otfr_pkg::OTFR_ST_NORMAL;
					tmr_stop   = 1'b1;
				end
				else if (tmr_done)
				begin
					next_tries = `OTFR_TRIES_ZERO;
					if (action.retries == `OTFR_RETRY_NONE)
						next_state = otfr_pkg::OTFR_ST_LATCH;
					else
					begin
						next_state = otfr_pkg::OTFR_ST_WAIT;
						tmr_start  = 1'b1;
					end
				end
			end
			otfr_pkg::OTFR_ST_WAIT:
			begin
				// an attempt starts at each interval end
				if (tmr_done)
				begin
					if (!fault)
						next_state = otfr_pkg::OTFR_ST_NORMAL;
					else if (action.retries != `OTFR_RETRY_FOREVER &&
						tries_inc >= {1'b0, action.retries})
						next_state = otfr_pkg::OTFR_ST_LATCH;
					else
					begin
						// failed attempt; next one a full interval on
						tmr_start = 1'b1;
						if (action.retries != `OTFR_RETRY_FOREVER)
							next_tries = tries + `OTFR_TRIES_ONE;
					end
				end
			end
			otfr_pkg::OTFR_ST_HOLD:
			begin
				// resume on its own once the fault is gone
				if (!fault)
					next_state = otfr_pkg::OTFR_ST_NORMAL;
			end
			otfr_pkg::OTFR_ST_LATCH:
			begin
				// stays off until cleared with the fault gone
				if (!fault && i_clear_fault)
					next_state = otfr_pkg::OTFR_ST_NORMAL;
			end
			default:
				next_state = otfr_pkg::OTFR_ST_NORMAL;
			endcase
		end
		// output runs only in the running states
		next_out_en = running &&
			(next_state == otfr_pkg::OTFR_ST_NORMAL ||
			 next_state == otfr_pkg::OTFR_ST_GRACE);
	end

	// state machine flops
	always_ff @(posedge i_mclk or posedge i_rst)
	begin
		if (i_rst)
		begin
			state       <= otfr_pkg::OTFR_ST_NORMAL;
			tries       <= `OTFR_TRIES_ZERO;
			o_output_en <= 1'b0;
		end
		else
		begin
			state       <= next_state;
			tries       <= next_tries;
			o_output_en <= next_out_en;
		end
	end

	// ------------------------------------------------------------------
	// status flag and alert
	// ------------------------------------------------------------------
	logic next_flag; // next sticky flag

	// a present fault beats a clear in the same cycle
	always_comb
	begin
		next_flag = o_ot_flag;
		if (i_clear_fault)
			next_flag = 1'b0;
		if (fault)
			next_flag = 1'b1;
	end

	// flag and alert flops
	always_ff @(posedge i_mclk or posedge i_rst)
	begin
		if (i_rst)
		begin
			o_ot_flag      <= 1'b0;
			o_alert_line_n <= 1'b1;
		end
		else
		begin
			o_ot_flag      <= next_flag;
			o_alert_line_n <= ~next_flag;
		end
	end

endmodule // otfr_fault_response
`default_nettype wire

/* tb/otfr_fault_response_assertions.sv */
// port checker for the over-temperature fault response block
`timescale 1ns/1ns
`default_nettype none
module otfr_fault_response_chk #(
	parameter int UNIT_W = 24 // unit length width
) (
	input wire logic              i_mclk,
	input wire logic              i_rst,
	input wire logic              i_wr_en,
	input wire logic [7:0]        i_wr_code,
	input wire logic [7:0]        i_wr_data,
	input wire logic              i_rd_en,
	input wire logic [7:0]        i_rd_code,
	input wire logic [15:0]       i_temp,
	input wire logic [15:0]       i_limit,
	input wire logic [UNIT_W-1:0] i_unit_cycles,
	input wire logic              i_cmd_on,
	input wire logic              i_other_fault,
	input wire logic              i_clear_fault,
	input wire logic [7:0]        o_rd_data,
	input wire logic              o_rd_valid,
	input wire logic              o_output_en,
	input wire logic              o_ot_flag,
	input wire logic              o_alert_line_n
);
	// ------------------------------------------------------------
	// shadow of the action byte and derived conditions
	// ------------------------------------------------------------
	otfr_pkg::otfr_action_s act; // last written action
	logic hot, cool, run;        // fault levels, output allowed
	logic ign, dly, dis, hld;    // response field decode
	assign hot = $signed(i_temp) > $signed(i_limit);
	assign cool = $signed(i_temp) < $signed(i_limit);
	assign run = i_cmd_on && !i_other_fault;
	assign ign = act.resp == otfr_pkg::OTFR_RESP_IGNORE;
	assign dly = act.resp == otfr_pkg::OTFR_RESP_DELAY;
	assign dis = act.resp == otfr_pkg::OTFR_RESP_DISABLE;
	assign hld = act.resp == otfr_pkg::OTFR_RESP_HOLD;
	// follow writes so that reads can be predicted
	always_ff @(posedge i_mclk or posedge i_rst)
		if (i_rst)
			act <= 8'h00;
		else if (i_wr_en && i_wr_code == 8'h50)
			act <= i_wr_data;
	default clocking cb @(posedge i_mclk); endclocking
	default disable iff (i_rst);
	// ------------------------------------------------------------
	// properties
	// ------------------------------------------------------------
	AST_ALERT_INV: assert property (o_alert_line_n == !o_ot_flag)
		else $error("alert is not the inverse of the flag");
	AST_FLAG_SET: assert property ((hot && run) [*3] |-> o_ot_flag)
		else $error("flag not set two cycles after fault");
	AST_FLAG_KEEP: assert property (o_ot_flag && !i_clear_fault |=> o_ot_flag)
		else $error("flag dropped without clear");
	AST_IGNORE_ON: assert property ((run && ign) [*2] |-> o_output_en)
		else $error("output off in ignore mode");
	AST_DISABLE_OFF: assert property ((run && hot && dis) [*3] |-> !o_output_en)
		else $error("output still on in disable mode");
	AST_HOLD_OFF: assert property ((run && hot && hld) [*3] |-> !o_output_en)
		else $error("output on during fault in hold mode");
	AST_HOLD_BACK: assert property ((run && cool && hld) [*4] |-> o_output_en)
		else $error("output not resumed after fault in hold mode");
	AST_GRACE_RUN: assert property (run && dly && o_output_en && $rose(hot) |=> o_output_en [*3])
		else $error("output dropped at start of delay");
	AST_READ: assert property (i_rd_en |=> o_rd_valid && o_rd_data == ($past(i_rd_code) == 8'h50 ? $past(act) : 8'h00))
		else $error("wrong read answer");
	AST_RD_PULSE: assert property (!i_rd_en |=> !o_rd_valid)
		else $error("read strobe without request");
	AST_OFF_CMD: assert property (!run [*2] |-> !o_output_en)
		else $error("output on while commanded off");
endmodule // otfr_fault_response_chk
bind otfr_fault_response otfr_fault_response_chk #(.UNIT_W(UNIT_W)) i_chk (
	.i_mclk(i_mclk), .i_rst(i_rst), .i_wr_en(i_wr_en),
	.i_wr_code(i_wr_code), .i_wr_data(i_wr_data), .i_rd_en(i_rd_en),
	.i_rd_code(i_rd_code), .i_temp(i_temp), .i_limit(i_limit),
	.i_unit_cycles(i_unit_cycles), .i_cmd_on(i_cmd_on),
	.i_other_fault(i_other_fault), .i_clear_fault(i_clear_fault),
	.o_rd_data(o_rd_data), .o_rd_valid(o_rd_valid),
	.o_output_en(o_output_en), .o_ot_flag(o_ot_flag),
	.o_alert_line_n(o_alert_line_n)
);
`default_nettype wire

/* tb/otfr_host_model.sv */
// host model driving the command write and read port
`timescale 1ns/1ns
`default_nettype none
module otfr_host_model (
	input  wire logic       i_mclk,     // system clock
	input  wire logic [7:0] i_rd_data,  // read answer
	input  wire logic       i_rd_valid, // answer strobe
	output logic            o_wr_en,    // write strobe
	output logic [7:0]      o_wr_code,  // write command code
	output logic [7:0]      o_wr_data,  // write data
	output logic            o_rd_en,    // read strobe
	output logic [7:0]      o_rd_code   // read command code
);
	// ------------------------------------------------------------
	// idle values, codes scrambled when not in use
	// ------------------------------------------------------------
	initial
	begin
		o_wr_en = 1'b0;
		o_rd_en = 1'b0;
		o_wr_code = 8'hAF;
		o_wr_data = 8'h5A;
		o_rd_code = 8'hAF;
	end
	// one write: strobe for one edge, then scramble
	task automatic write_cmd(input logic [7:0] code, input logic [7:0] data);
		@(posedge i_mclk) #1;
		o_wr_en = 1'b1;
		o_wr_code = code;
		o_wr_data = data;
		@(posedge i_mclk) #1;
		o_wr_en = 1'b0;
		o_wr_code = ~code;
		o_wr_data = ~data;
	endtask
	// one read: answer is sampled 1 ns after the strobe edge, which registers it
	task automatic read_cmd(input logic [7:0] code, output logic [8:0] ans);
		@(posedge i_mclk) #1;
		o_rd_en = 1'b1;
		o_rd_code = code;
		@(posedge i_mclk) #1;
		o_rd_en = 1'b0;
		o_rd_code = ~code;
		ans = {i_rd_valid, i_rd_data};
	endtask
endmodule // otfr_host_model
`default_nettype wire

/* tb/otfr_fault_response_tb.sv */
// self-checking bench for the fault response block
`timescale 1ns/1ns
`default_nettype none
module otfr_fault_response_tb;
	// ------------------------------------------------------------
	// signals and counters
	// ------------------------------------------------------------
	localparam logic [15:0] HOT = 16'h0070;  // above the limit
	localparam logic [15:0] COOL = 16'hFFF0; // negative, below
	logic i_mclk, i_rst, wr_en, rd_en, rd_valid;
	logic i_cmd_on, i_other_fault, i_clear_fault;
	logic out_en, flag, alert_n;
	logic [7:0] wr_code, wr_data, rd_code, rd_data, unit;
	logic [15:0] i_temp, i_limit;
	int n_fail = 0;
	int cmp_count = 0;
	otfr_host_model i_host (.i_mclk(i_mclk), .i_rd_data(rd_data),
		.i_rd_valid(rd_valid), .o_wr_en(wr_en), .o_wr_code(wr_code),
		.o_wr_data(wr_data), .o_rd_en(rd_en), .o_rd_code(rd_code));
	otfr_fault_response #(.UNIT_W(8)) i_dut (.i_mclk(i_mclk),
		.i_rst(i_rst), .i_wr_en(wr_en), .i_wr_code(wr_code),
		.i_wr_data(wr_data), .i_rd_en(rd_en), .i_rd_code(rd_code),
		.i_temp(i_temp), .i_limit(i_limit), .i_unit_cycles(unit),
		.i_cmd_on(i_cmd_on), .i_other_fault(i_other_fault),
		.i_clear_fault(i_clear_fault), .o_rd_data(rd_data),
		.o_rd_valid(rd_valid), .o_output_en(out_en), .o_ot_flag(flag),
		.o_alert_line_n(alert_n));
	initial
	begin
		i_mclk = 1'b0;
		forever #5 i_mclk = ~i_mclk;
	end
	// ------------------------------------------------------------
	// shared tasks
	// ------------------------------------------------------------
	task automatic check(input string what, input logic [15:0] seen,
		input logic [15:0] exp);
		cmp_count++;
		if (seen !== exp)
		begin
			n_fail++;
			$display("MISMATCH %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic close_out();
		$display("comparisons %0d mismatches %0d", cmp_count, n_fail);
		if (n_fail == 0 && cmp_count > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge i_mclk) #1;
	endtask
	// bounded wait for the output enable to reach a level
	task automatic wait_out(input logic v, input int lim, output int c);
		c = 0;
		while (out_en !== v)
		begin
			cyc(1);
			c++;
			if (c > lim)
			begin
				check("output wait", out_en, v);
				close_out();
			end
		end
	endtask
	// off command resets the machine, then new action and on
	task automatic setup(input logic [7:0] act);
		i_cmd_on = 1'b0;
		i_temp = COOL;
		i_clear_fault = 1'b1;
		cyc(2);
		i_clear_fault = 1'b0;
		i_host.write_cmd(8'h50, act);
		i_cmd_on = 1'b1;
		cyc(3);
	endtask
	// ------------------------------------------------------------
	// scenarios
	// ------------------------------------------------------------
	task automatic t_regs();
		logic [8:0] a;
		i_host.read_cmd(8'h50, a);
		check("reset action", a, 9'h100);
		i_host.write_cmd(8'h50, 8'hA5);
		i_host.write_cmd(8'h51, 8'h3C);
		i_host.read_cmd(8'h50, a);
		check("action readback", a, 9'h1A5);
		i_host.read_cmd(8'h51, a);
		check("unmapped read", a, 9'h100);
		$display("test regs done");
	endtask
	task automatic t_ignore();
		setup(8'h00);
		i_temp = HOT;
		cyc(20);
		check("ignore output", out_en, 1);
		check("flag set", flag, 1);
		check("alert low", alert_n, 0);
		i_temp = COOL;
		i_clear_fault = 1'b1;
		cyc(3);
		i_clear_fault = 1'b0;
		check("flag cleared", flag, 0);
		$display("test ignore done");
	endtask
	task automatic t_space(input logic [2:0] d);
		int c;
		setup({2'b10, 3'h1, d});
		i_temp = HOT;
		wait_out(0, 5, c);
		i_temp = COOL;
		wait_out(1, 600, c);
		check("interval", c >= (4 << d) - 2 && c <= (4 << d) + 3, 1);
	endtask
	task automatic t_tries(input logic [2:0] n);
		int c;
		if (n != 0)
		begin
			setup({2'b10, n, 3'h2});
			i_temp = HOT;
			wait_out(0, 5, c);
			cyc(n * 17 - 9);
			i_temp = COOL;
			cyc(30);
			check("last attempt", out_en, 1);
		end
		setup({2'b10, n, 3'h2});
		i_temp = HOT;
		wait_out(0, 5, c);
		cyc(n * 17 + 9);
		i_temp = COOL;
		cyc(60);
		check("latched off", out_en, 0);
		i_clear_fault = 1'b1;
		cyc(1);
		i_clear_fault = 1'b0;
		cyc(5);
		check("on after clear", out_en, 1);
	endtask
	task automatic t_forever();
		int c;
		setup(8'hB8);
		i_temp = HOT;
		cyc(80);
		check("off while retrying", out_en, 0);
		i_temp = COOL;
		wait_out(1, 12, c);
		i_temp = HOT;
		wait_out(0, 5, c);
		i_other_fault = 1'b1;
		cyc(2);
		i_temp = COOL;
		cyc(20);
		check("other fault stops", out_en, 0);
		i_other_fault = 1'b0;
		$display("test forever done");
	endtask
	task automatic t_grace();
		int c;
		unit = 8'h06;
		setup(8'h42);
		i_temp = HOT;
		wait_out(0, 40, c);
		check("grace length", c >= 24 && c <= 30, 1);
		i_temp = COOL;
		cyc(30);
		check("no retry latch", out_en, 0);
		// fault gone inside the delay, then a fault that outlasts it
		setup(8'h4A);
		i_temp = HOT;
		cyc(10);
		check("grace still on", out_en, 1);
		i_temp = COOL;
		cyc(40);
		check("grace fault gone", out_en, 1);
		i_temp = HOT;
		wait_out(0, 40, c);
		i_temp = COOL;
		wait_out(1, 40, c);
		check("grace retry", c >= 24 && c <= 27, 1);
		unit = 8'h04;
		$display("test grace done");
	endtask
	task automatic t_hold();
		int c;
		setup(8'hC0);
		i_temp = HOT;
		wait_out(0, 5, c);
		cyc(30);
		check("hold off", out_en, 0);
		i_temp = i_limit;
		cyc(10);
		check("equal keeps fault", out_en, 0);
		i_temp = COOL;
		wait_out(1, 5, c);
		check("flag sticky", flag, 1);
		$display("test hold done");
	endtask
	// reset in mid-run returns outputs and action to reset values
	task automatic t_reset();
		logic [8:0] a;
		setup(8'h00);
		i_temp = HOT;
		cyc(10);
		check("flag before reset", flag, 1);
		i_rst = 1'b1;
		cyc(2);
		check("reset output", out_en, 0);
		check("reset flag", flag, 0);
		check("reset alert", alert_n, 1);
		i_temp = COOL;
		i_rst = 1'b0;
		cyc(2);
		check("on after reset", out_en, 1);
		i_host.read_cmd(8'h50, a);
		check("action after reset", a, 9'h100);
		$display("test reset done");
	endtask
	// ------------------------------------------------------------
	// main sequence
	// ------------------------------------------------------------
	initial
	begin
		i_rst = 1'b1;
		i_temp = COOL;
		i_limit = 16'h0064;
		unit = 8'h04;
		i_cmd_on = 1'b0;
		i_other_fault = 1'b0;
		i_clear_fault = 1'b0;
		repeat (12) @(posedge i_mclk);
		#1 i_rst = 1'b0;
		t_regs();
		t_ignore();
		for (int d = 0; d < 8; d++)
			t_space(d[2:0]);
		$display("test spacing done");
		for (int n = 0; n < 7; n++)
			t_tries(n[2:0]);
		$display("test tries done");
		t_forever();
		t_grace();
		t_hold();
		t_reset();
		close_out();
	end
endmodule // otfr_fault_response_tb
`default_nettype wire
